// ==== fod_pkg.sv ====
// Purpose: shared constants for the field output mode and fault block
// Assumes: 32-bit APB, one word per register
// Notes: fault bits double as interrupt event bits
package fod_pkg;
    localparam int NUM_OUT = 16;
    localparam int GRP_SIZE = 8;
    localparam int NUM_GRP = 2;
    localparam int NUM_FLT = 5;
    localparam logic [7:0] ADDR_SRC_MASK = 8'h00;
    localparam logic [7:0] ADDR_SNK_MASK = 8'h04;
    localparam logic [7:0] ADDR_OUT_DATA = 8'h08;
    localparam logic [7:0] ADDR_FAULT = 8'h0C;
    localparam logic [7:0] ADDR_SHORT_DIS = 8'h10;
    localparam logic [7:0] ADDR_DRV_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_STAT = 8'h18;
    localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
    localparam int FLT_HOST = 0;
    localparam int FLT_SHORT = 1;
    localparam int FLT_TEMP = 2;
    localparam int FLT_LOWV = 3;
    localparam int FLT_RANGE = 4;
    localparam logic [4:0] FAULT_RST = 5'h01;
    localparam logic [15:0] MASK16_RST = 16'h0000;
    localparam logic [4:0] INT_MASK_RST = 5'h00;
    localparam int DRV_STAT_CHIP = 16;
    localparam int DRV_STAT_BANK = 18;
    localparam int DRV_STAT_RUN = 20;
    typedef enum logic [1:0] {
        FOD_WAIT_SUPPLY = 2'b01,
        FOD_RUN = 2'b10
    } fod_state_t;
endpackage

// ==== fod_drive.sv ====
// Purpose: per-output high/low switch selection from mode masks
// Assumes: purely combinational, registered by the caller
// Notes: both masks zero leaves the output floating
`timescale 1ns/1ps
`default_nettype none
module fod_drive
    import fod_pkg::*;
(
    input wire logic [15:0] src_mask_in,
    input wire logic [15:0] snk_mask_in,
    input wire logic [15:0] data_in,
    input wire logic [15:0] enable_in,
    output logic [15:0] hs_on_out,
    output logic [15:0] ls_on_out
);
    genvar n;
    generate
        for (n = 0; n < NUM_OUT; n = n + 1)
        begin : g_out
            wire logic src_only;
            wire logic snk_only;
            wire logic push_pull;
            assign src_only = src_mask_in[n] & ~snk_mask_in[n];
            assign snk_only = snk_mask_in[n] & ~src_mask_in[n];
            assign push_pull = src_mask_in[n] & snk_mask_in[n];
            // a disabled output opens both switches whatever the mode
            assign hs_on_out[n] = enable_in[n] & data_in[n]
                & (src_only | push_pull);
            assign ls_on_out[n] = enable_in[n]
                & ((snk_only & data_in[n])
                | (push_pull & ~data_in[n]));
        end
    endgenerate
endmodule
`default_nettype wire

// ==== fod_ctrl.sv ====
// Purpose: field output mode control and protection fault handling
// Assumes: driver flags and supply monitors are synchronous to ref_clk_in
// Notes: APB slave answers with no wait state; reads of INT_STAT clear it
//
// Function
// - two 16-bit masks, source and sink, bit n controls output n
// - source one and sink zero gives sourcing drive
// - sink one and source zero gives sinking drive
// - both mask bits one gives push-pull drive, high and low
// - short circuit disables that single output and raises a fault
// - chip over-temperature disables all its outputs and raises a fault
// - outputs 0-7 form one driver group, outputs 8-15 the other
// - outputs 0-7 on supply bank A, outputs 8-15 on bank B
// - missing bank supply blocks normal operation and flags low voltage
// - field supply too high or too low raises a fault
// - output writes ignored while any fault is set; host clears it
// - fault flag is set out of reset, outputs inhibited until cleared
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fod_ctrl
    import fod_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [15:0] short_in,
    input wire logic [1:0] overtemp_in,
    input wire logic bank_a_field_supply_in,
    input wire logic bank_b_field_supply_in,
    input wire logic [1:0] supply_high_in,
    input wire logic [1:0] supply_low_in,
    output logic [15:0] hs_on_out,
    output logic [15:0] ls_on_out,
    output logic fault_out,
    output logic irq_out
);
    logic [15:0] src_mask;
    logic [15:0] snk_mask;
    logic [15:0] out_data;
    logic [4:0] fault;
    logic [15:0] short_dis;
    logic [1:0] chip_dis;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    fod_state_t state;
    fod_state_t next_state;

    // bus decode
    wire logic setup_ph;
    wire logic access_ph;
    wire logic wr_en;
    wire logic rd_en;
    wire logic sel_src;
    wire logic sel_snk;
    wire logic sel_out;
    wire logic sel_flt;
    wire logic sel_sdis;
    wire logic sel_dstat;
    wire logic sel_istat;
    wire logic sel_imask;
    wire logic sel_any;
    assign setup_ph = psel_in & ~penable_in;
    assign access_ph = psel_in & penable_in & pready_out;
    assign wr_en = access_ph & pwrite_in;
    assign rd_en = access_ph & ~pwrite_in;
    assign sel_src = paddr_in == ADDR_SRC_MASK;
    assign sel_snk = paddr_in == ADDR_SNK_MASK;
    assign sel_out = paddr_in == ADDR_OUT_DATA;
    assign sel_flt = paddr_in == ADDR_FAULT;
    assign sel_sdis = paddr_in == ADDR_SHORT_DIS;
    assign sel_dstat = paddr_in == ADDR_DRV_STAT;
    assign sel_istat = paddr_in == ADDR_INT_STAT;
    assign sel_imask = paddr_in == ADDR_INT_MASK;
    assign sel_any = sel_src | sel_snk | sel_out | sel_flt | sel_sdis
        | sel_dstat | sel_istat | sel_imask;

    // supplies and protection
    wire logic banks_ok;
    wire logic any_fault;
    wire logic range_bad;
    wire logic [15:0] short_hit;
    wire logic [1:0] temp_hit;
    wire logic [4:0] fault_set;
    wire logic [4:0] fault_clr;
    wire logic [4:0] next_fault;
    wire logic [15:0] next_short_dis;
    wire logic [1:0] next_chip_dis;
    wire logic [15:0] grp_dis;
    wire logic [15:0] out_enable;
    wire logic [15:0] drv_hs;
    wire logic [15:0] drv_ls;
    wire logic [4:0] next_int_stat;
    wire logic [31:0] drv_stat_word;
    wire logic [31:0] rd_word;
    wire logic running;

    assign banks_ok = bank_a_field_supply_in & bank_b_field_supply_in;
    assign range_bad = |supply_high_in | |supply_low_in;
    assign running = state == FOD_RUN;
    assign any_fault = |fault;
    assign short_hit = short_in & ~short_dis;
    assign temp_hit = overtemp_in;

    assign fault_set[FLT_HOST] = 1'b0;
    assign fault_set[FLT_SHORT] = |short_hit;
    assign fault_set[FLT_TEMP] = |temp_hit;
    assign fault_set[FLT_LOWV] = ~banks_ok;
    assign fault_set[FLT_RANGE] = range_bad;
    // write one to clear; a fresh event in the same cycle keeps the bit
    assign fault_clr = (wr_en & sel_flt) ? pwdata_in[4:0] : 5'h00;
    assign next_fault = fault_set | (fault & ~fault_clr);

    assign next_short_dis = short_hit | short_dis
        & ~((wr_en & sel_sdis) ? pwdata_in[15:0] : 16'h0000);
    // chip latch is released with the temperature fault bit
    assign next_chip_dis = temp_hit | chip_dis
        & ~{2{fault_clr[FLT_TEMP]}};

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1)
        begin : g_grp
            // group index equals supply bank index
            assign grp_dis[g] = chip_dis[g / GRP_SIZE];
        end
    endgenerate

    assign out_enable = {NUM_OUT{running & ~any_fault}}
        & ~short_dis & ~grp_dis;

    fod_drive u_drive (
        .src_mask_in(src_mask),
        .snk_mask_in(snk_mask),
        .data_in(out_data),
        .enable_in(out_enable),
        .hs_on_out(drv_hs),
        .ls_on_out(drv_ls)
    );

    // rising fault bits are the interrupt events; read clears, set wins
    assign next_int_stat = (next_fault & ~fault)
        | (int_stat & ~((rd_en & sel_istat) ? 5'h1F : 5'h00));

    assign drv_stat_word = {11'h000, running,
        bank_b_field_supply_in, bank_a_field_supply_in,
        chip_dis, out_enable};
    assign rd_word = sel_src ? {16'h0000, src_mask}
        : sel_snk ? {16'h0000, snk_mask}
        : sel_out ? {16'h0000, out_data}
        : sel_flt ? {27'h0000000, fault}
        : sel_sdis ? {16'h0000, short_dis}
        : sel_dstat ? drv_stat_word
        : sel_istat ? {27'h0000000, int_stat}
        : sel_imask ? {27'h0000000, int_mask}
        : 32'h00000000;

    // supply gate for normal operation
    always_comb
    begin
        case (state)
            FOD_WAIT_SUPPLY: next_state = banks_ok ? FOD_RUN
                : FOD_WAIT_SUPPLY;
            FOD_RUN: next_state = banks_ok ? FOD_RUN
                : FOD_WAIT_SUPPLY;
            default: next_state = FOD_WAIT_SUPPLY;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state <= FOD_WAIT_SUPPLY;
            fault <= FAULT_RST;
            short_dis <= 16'h0000;
            chip_dis <= 2'h0;
            int_stat <= 5'h00;
        end
        else
        begin
            state <= next_state;
            fault <= next_fault;
            short_dis <= next_short_dis;
            chip_dis <= next_chip_dis;
            int_stat <= next_int_stat;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            src_mask <= MASK16_RST;
            snk_mask <= MASK16_RST;
            out_data <= 16'h0000;
            int_mask <= INT_MASK_RST;
        end
        else
        begin
            if (wr_en & sel_src)
                src_mask <= pwdata_in[15:0];
            if (wr_en & sel_snk)
                snk_mask <= pwdata_in[15:0];
            if (wr_en & sel_out & ~any_fault)
                out_data <= pwdata_in[15:0];
            if (wr_en & sel_imask)
                int_mask <= pwdata_in[4:0];
        end
    end

    // answer in the first access cycle; unmapped addresses give pslverr
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end
        else
        begin
            pready_out <= setup_ph;
            pslverr_out <= setup_ph & ~sel_any;
            prdata_out <= (setup_ph & ~pwrite_in) ? rd_word : 32'h00000000;
        end
    end

    // switch pins lag the registers by one cycle so they come from flops; fault_out and irq_out track fault and int_stat, irq_out sees int_mask one cycle late
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            hs_on_out <= 16'h0000;
            ls_on_out <= 16'h0000;
            fault_out <= 1'b1;
            irq_out <= 1'b0;
        end
        else
        begin
            hs_on_out <= drv_hs;
            ls_on_out <= drv_ls;
            fault_out <= |next_fault;
            irq_out <= |(next_int_stat & int_mask);
        end
    end
endmodule
`default_nettype wire

// ==== fod_chk.sv ====
// Purpose: port-level checks for fod_ctrl
// Assumes: one clock domain, async active-high reset
// Notes: an input event reaches fault_out one edge later and the switch pins two edges later
`timescale 1ns/1ps
`default_nettype none
module fod_chk (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] short_in,
    input wire logic [1:0] overtemp_in,
    input wire logic bank_a_field_supply_in,
    input wire logic bank_b_field_supply_in,
    input wire logic [1:0] supply_high_in,
    input wire logic [1:0] supply_low_in,
    input wire logic [15:0] hs_on_out,
    input wire logic [15:0] ls_on_out,
    input wire logic fault_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    start_fault_a: assert property ($fell(sys_rst_in) |-> fault_out)
        else $error("fault not set after reset");
    // the switch pins are one edge behind the fault flag, so look one later
    fault_quiet_a: assert property (fault_out |=>
        (hs_on_out | ls_on_out) == 16'h0000)
        else $error("pin driven while faulted");
    no_overlap_a: assert property ((hs_on_out & ls_on_out) == 16'h0000)
        else $error("both switches on");
    short_off_a: assert property (short_in != 16'h0000 |-> ##2
        ((hs_on_out | ls_on_out) & $past(short_in, 2)) == 16'h0000)
        else $error("shorted output still driven");
    short_flag_a: assert property (short_in != 16'h0000 |-> ##2 fault_out)
        else $error("short without fault");
    chip_lo_a: assert property (overtemp_in[0] |-> ##2
        (hs_on_out[7:0] | ls_on_out[7:0]) == 8'h00 && fault_out)
        else $error("chip 0 not shut down");
    chip_hi_a: assert property (overtemp_in[1] |-> ##2
        (hs_on_out[15:8] | ls_on_out[15:8]) == 8'h00 && fault_out)
        else $error("chip 1 not shut down");
    low_supply_a: assert property (!(bank_a_field_supply_in &&
        bank_b_field_supply_in) |-> ##2 fault_out)
        else $error("missing supply without fault");
    supply_range_a: assert property ((supply_high_in | supply_low_in) != 2'h0
        |-> ##2 fault_out)
        else $error("supply out of range without fault");
endmodule
`default_nettype wire

// ==== fod_far.sv ====
// Purpose: driver chip model: short and over-temperature flags
// Assumes: a short is only seen while a switch of that output is on
// Notes: level flags, no latching; the controller must hold them
`timescale 1ns/1ps
`default_nettype none
module fod_far (
    input wire logic [15:0] hs_on_in,
    input wire logic [15:0] ls_on_in,
    input wire logic [15:0] load_short_in,
    input wire logic [1:0] hot_in,
    output logic [15:0] short_out,
    output logic [1:0] overtemp_out
);
    // a shorted load draws no current until its switch closes
    assign short_out = load_short_in & (hs_on_in | ls_on_in);
    assign overtemp_out = hot_in;
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for fod_ctrl over APB
// Assumes: zero-wait-state slave, switch pins lag registers by one edge
// Notes: driver chips come from fod_far
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fod_pkg::*;
    logic ref_clk_in;
    logic sys_rst_in = 1;
    logic psel_in = 0;
    logic penable_in = 0;
    logic pwrite_in = 0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, fault_out, irq_out;
    logic [15:0] short_in, hs_on_out, ls_on_out, d;
    logic [1:0] overtemp_in;
    logic bank_a_field_supply_in = 1;
    logic bank_b_field_supply_in = 1;
    logic [1:0] supply_high_in = 2'h0;
    logic [1:0] supply_low_in = 2'h0;
    logic [15:0] lshort = 16'h0000;
    logic [1:0] hot = 2'h0;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [15:0] src = 16'hCCCC;
    logic [15:0] snk = 16'hAAAA;
    logic [15:0] pat [3] = '{16'hF0F0, 16'h0F0F, 16'hFFFF};
    logic [31:0] rv [8] = '{0, 0, 0, 1, 0, 32'h001C0000, 0, 0};
    fod_ctrl dut_u (.ref_clk_in, .sys_rst_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .short_in, .overtemp_in, .bank_a_field_supply_in,
        .bank_b_field_supply_in, .supply_high_in, .supply_low_in,
        .hs_on_out, .ls_on_out, .fault_out, .irq_out);
    fod_far far_u (.hs_on_in(hs_on_out), .ls_on_in(ls_on_out),
        .load_short_in(lshort), .hot_in(hot), .short_out(short_in),
        .overtemp_out(overtemp_in));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge ref_clk_in);
        penable_in <= 1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        ref_clk_in = 0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    initial
    begin
        // generous margin over the few hundred cycles the tests need
        #(50 * 4000);
        n_mismatch++;
        test_done();
    end
    initial
    begin
        wt(20);
        sys_rst_in <= 0;
        wt(1);
        chk("fault_out", 1, {31'h0, fault_out});
        for (int i = 0; i < 8; i++)
            rdc(8'(4 * i), rv[i], "reset value");
        apb(0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1, ADDR_OUT_DATA, 32'hFFFF);
        rdc(ADDR_OUT_DATA, 32'h0, "out_data in fault");
        apb(1, ADDR_FAULT, 32'h1);
        wt(2);
        chk("fault_out", 0, {31'h0, fault_out});
        apb(1, ADDR_SRC_MASK, {16'h0, src});
        apb(1, ADDR_SNK_MASK, {16'h0, snk});
        rdc(ADDR_SNK_MASK, {16'h0, snk}, "sink mask");
        foreach (pat[i])
        begin
            d = pat[i];
            apb(1, ADDR_OUT_DATA, {16'h0, d});
            wt(2);
            chk("hs", {16'h0, d & src}, {16'h0, hs_on_out});
            chk("ls", {16'h0, (d & snk & ~src) | (~d & snk & src)}, {16'h0, ls_on_out});
        end
        apb(1, ADDR_INT_MASK, 32'h2);
        lshort <= 16'h0080;
        wt(4);
        lshort <= 16'h0000;
        chk("irq", 1, {31'h0, irq_out});
        rdc(ADDR_FAULT, 32'h2, "short fault");
        rdc(ADDR_SHORT_DIS, 32'h80, "short disable");
        rdc(ADDR_INT_STAT, 32'h2, "int stat");
        wt(1);
        chk("irq clear", 0, {31'h0, irq_out});
        apb(1, ADDR_FAULT, 32'h2);
        wt(2);
        chk("hs one off", 32'hCC4C, {16'h0, hs_on_out});
        apb(1, ADDR_SHORT_DIS, 32'h80);
        hot <= 2'b10;
        wt(3);
        hot <= 2'b00;
        chk("irq masked", 0, {31'h0, irq_out});
        rdc(ADDR_DRV_STAT, 32'h001E0000, "chip off");
        apb(1, ADDR_INT_MASK, 32'h4);
        wt(2);
        chk("irq unmasked", 1, {31'h0, irq_out});
        rdc(ADDR_INT_STAT, 32'h4, "int stat");
        apb(1, ADDR_FAULT, 32'h4);
        wt(2);
        rdc(ADDR_DRV_STAT, 32'h001CFFFF, "all on");
        hot <= 2'b01;
        wt(3);
        hot <= 2'b00;
        rdc(ADDR_DRV_STAT, 32'h001D0000, "chip 0 off");
        apb(1, ADDR_FAULT, 32'h4);
        wt(2);
        for (int i = 0; i < 2; i++)
        begin
            bank_a_field_supply_in <= (i != 0);
            bank_b_field_supply_in <= (i == 0);
            wt(3);
            rdc(ADDR_DRV_STAT, (i == 0) ? 32'h80000 : 32'h40000, "bank");
            rdc(ADDR_FAULT, 32'h8, "low voltage");
            bank_a_field_supply_in <= 1;
            bank_b_field_supply_in <= 1;
            wt(2);
            apb(1, ADDR_FAULT, 32'h8);
        end
        for (int i = 0; i < 4; i++)
        begin
            {supply_high_in, supply_low_in} <= 4'(1 << i);
            wt(3);
            rdc(ADDR_FAULT, 32'h10, "range");
            {supply_high_in, supply_low_in} <= 4'h0;
            wt(2);
            apb(1, ADDR_FAULT, 32'h10);
        end
        wt(2);
        chk("fault_out", 0, {31'h0, fault_out});
        test_done();
    end
endmodule
bind fod_ctrl fod_chk chk_u (.ref_clk_in, .sys_rst_in, .short_in,
    .overtemp_in, .bank_a_field_supply_in, .bank_b_field_supply_in,
    .supply_high_in, .supply_low_in, .hs_on_out, .ls_on_out, .fault_out);
`default_nettype wire
